/* File: hw/dram_board_ctl.sv */
// control logic of a four-way interleaved dynamic RAM board
// Behaviour
// - on the start strobe, capture and decode the 17-bit address from the input bus
// - largest variant ignores board select lines; it is always selected
// - smaller variants match board lines against jumpers before module/bank decode
// - single-bank variants decode no bank bit; everything goes to bank zero
// - a timing generator sequences capture, decode and issue after the start strobe
// - each module latches its own row and column address parts
// - row enable drives the row address first, then column enable the column
// - write strobe captures the input bus word into the write-data latch
// - write strobe reaches the module's write enable through its write latch
// - four-to-one mux loads the finishing module's read word into an output register
// - the loaded output register drives the read data bus toward the CPU
// - output registers are used in strict rotation, one per operation
// - refresh starts only while all four modules are idle
// - refresh every 25 us on small variants, 13 us on large ones
// - refresh forces row enable on all modules with its own row address
// - low power-good with battery backup keeps refresh running
// - on battery power, only refresh runs; reads and writes are not started
// - selecting the board during a clashing operation or refresh raises busy
// - the low two address bits pick the module, so consecutive words interleave
// - each module runs its own 400 ns cycle, overlapping other modules
`timescale 1ns/10ps
module dram_board_ctl
   import dram_board_pkg::*;
(
   input  wire logic                                clk_i,                    // board clock
   input  wire logic                                resetn_i,                 // async reset
   input  wire logic                                ce_i,                     // clock enable
   input  wire logic                                op_start_strobe_i,        // op starting
   input  wire logic                                write_strobe_i,           // write op
   input  wire logic                                select_inhibit_i,         // cpu-fpu xfer
   input  wire logic [ADDR_W-1:0]                   addr_data_in_bus_i,       // address/data
   input  wire logic                                power_good_i,             // dc ok
   input  wire logic                                battery_option_i,         // strap
   input  wire board_size_t                         board_size_i,             // variant strap
   input  wire logic [BOARD_RANGE_W-1:0]            board_range_i,            // jumpers
   input  wire logic [NUM_MODULES-1:0][DATA_W-1:0]  ram_read_data_i,          // ram outputs
   output logic [NUM_MODULES-1:0]                   module_row_addr_enable_o, // row phase
   output logic [NUM_MODULES-1:0]                   module_col_addr_enable_o, // col phase
   output logic [NUM_MODULES-1:0][RAM_ADDR_W-1:0]   ram_addr_o,               // ram address
   output logic [NUM_MODULES-1:0]                   ram_bank_o,               // bank select
   output logic [NUM_MODULES-1:0]                   ram_we_o,                 // write enable
   output logic [DATA_W-1:0]                        latched_write_data_o,     // ram data in
   output logic [DATA_W-1:0]                        read_data_out_bus_o,      // read data
   output logic                                     read_data_valid_o,        // read pulse
   output logic                                     board_busy_response_o,    // busy pulse
   output logic                                     refresh_active_o          // in refresh
);
   tg_state_t               tg_state;
   logic [ADDR_W-1:0]       cap_addr;
   logic                    cap_write;
   logic                    dec_sel;
   logic                    dec_bank;
   logic [RAM_ADDR_W-1:0]   dec_row;
   logic [RAM_ADDR_W-1:0]   dec_col;
   logic [MOD_SEL_W-1:0]    dec_mod;
   logic [MOD_SEL_W-1:0]    iss_mod;
   logic                    iss_bank;
   logic [RAM_ADDR_W-1:0]   iss_row;
   logic [RAM_ADDR_W-1:0]   iss_col;
   logic                    iss_write;
   logic [MOD_SEL_W-1:0]    last_mod;
   logic                    last_valid;
   logic [OREG_IDX_W-1:0]   oreg_ptr;
   logic [NUM_MODULES-1:0]  mod_busy;
   logic [NUM_MODULES-1:0]  mod_in_row;
   logic [NUM_MODULES-1:0]  rd_done;
   logic [OREG_IDX_W-1:0]   mod_oreg [NUM_MODULES];
   logic [MOD_SEL_W-1:0]    done_idx;
   logic                    done_any;
   logic                    all_idle;
   logic                    battery_mode;
   logic                    refresh_en;
   logic                    clash;
   logic                    issue;
   logic                    take_start;
   logic [REF_CNT_W-1:0]    ref_timer;
   logic                    ref_due;
   logic                    ref_start;
   logic [CNT_W-1:0]        ref_cnt;
   logic                    refreshing;
   logic [RAM_ADDR_W-1:0]   ref_row;
   logic                    busy_pulse;

   outreg_if oport ();

   outreg_bank u_outreg_bank (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .port     (oport.bank)
   );

   assign battery_mode = battery_option_i && !power_good_i;
   // without the battery option a power loss drops contents anyway
   assign refresh_en   = power_good_i || battery_option_i;
   assign all_idle     = (mod_busy == '0);
   assign issue        = (tg_state == TG_ISSUE);
   assign take_start   = op_start_strobe_i && !select_inhibit_i && !battery_mode;
   assign dec_mod      = cap_addr[MOD_LSB +: MOD_SEL_W];
   assign clash        = mod_busy[dec_mod] || refreshing;

   // address decode per board variant
   always_comb begin
      dec_sel  = 1'b0;
      dec_bank = 1'b0;
      dec_row  = cap_addr[LARGE_ROW_LSB +: RAM_ADDR_W];
      dec_col  = cap_addr[LARGE_COL_LSB +: RAM_ADDR_W];
      unique case (board_size_i)
         SIZE_256K: begin
            dec_sel  = 1'b1;
            dec_bank = cap_addr[LARGE_BANK_BIT];
         end
         SIZE_128K: begin
            dec_sel  = (cap_addr[BOARD_MSB] == board_range_i[BOARD_RANGE_W-1]);
         end
         SIZE_64K: begin
            dec_sel  = (cap_addr[BOARD_MSB -: 2] == board_range_i[BOARD_RANGE_W-1 -: 2]);
            dec_bank = cap_addr[SMALL_BANK_BIT];
            dec_row  = {1'b0, cap_addr[SMALL_ROW_LSB +: SMALL_RC_W]};
            dec_col  = {1'b0, cap_addr[SMALL_COL_LSB +: SMALL_RC_W]};
         end
         SIZE_32K: begin
            dec_sel  = (cap_addr[BOARD_MSB -: BOARD_RANGE_W] == board_range_i);
            dec_row  = {1'b0, cap_addr[SMALL_ROW_LSB +: SMALL_RC_W]};
            dec_col  = {1'b0, cap_addr[SMALL_COL_LSB +: SMALL_RC_W]};
         end
      endcase
   end

   // interface timing generator: capture, decode, issue
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tg_state <= TG_IDLE;
         cap_addr <= '0;
         iss_mod  <= '0;
         iss_bank <= 1'b0;
         iss_row  <= '0;
         iss_col  <= '0;
      end else if (ce_i) begin
         unique case (tg_state)
            TG_IDLE: begin
               if (take_start) begin
                  cap_addr <= addr_data_in_bus_i;
                  tg_state <= TG_DECODE;
               end
            end
            TG_DECODE: begin
               iss_mod  <= dec_mod;
               iss_bank <= dec_bank;
               iss_row  <= dec_row;
               iss_col  <= dec_col;
               tg_state <= (dec_sel && !clash && !battery_mode) ? TG_ISSUE : TG_IDLE;
            end
            TG_ISSUE: begin
               tg_state <= TG_IDLE;
            end
            default: begin
               tg_state <= TG_IDLE;
            end
         endcase
      end
   end

   // a write strobe may come with the start or during the row phase
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cap_write <= 1'b0;
         iss_write <= 1'b0;
      end else if (ce_i) begin
         if (tg_state == TG_IDLE) begin
            cap_write <= take_start && write_strobe_i;
         end else if (tg_state == TG_DECODE) begin
            iss_write <= cap_write || write_strobe_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         latched_write_data_o <= '0;
      end else if (ce_i && write_strobe_i) begin
         latched_write_data_o <= addr_data_in_bus_i[DATA_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_pulse <= 1'b0;
      end else if (ce_i) begin
         busy_pulse <= (tg_state == TG_DECODE) && dec_sel && clash && !battery_mode;
      end
   end
   assign board_busy_response_o = busy_pulse;

   // one output register per operation, rotating regardless of module
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         oreg_ptr   <= '0;
         last_mod   <= '0;
         last_valid <= 1'b0;
      end else if (ce_i && issue) begin
         oreg_ptr   <= oreg_ptr + 2'h1;
         last_mod   <= iss_mod;
         last_valid <= 1'b1;
      end
   end

   // per-module timing generator and address latches
   for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
      logic [CNT_W-1:0]      cnt;
      logic [RAM_ADDR_W-1:0] row_l;
      logic [RAM_ADDR_W-1:0] col_l;
      logic                  bank_l;
      logic                  wr_l;
      logic [OREG_IDX_W-1:0] oreg_l;
      logic                  start;
      logic                  wr_hit;
      logic                  row_en;
      logic                  col_en;
      logic                  we;
      logic                  bank_q;
      logic [RAM_ADDR_W-1:0] addr_q;

      assign start         = issue && (iss_mod == MOD_SEL_W'(m));
      assign mod_busy[m]   = (cnt != '0);
      assign mod_in_row[m] = mod_busy[m] && (cnt > COL_START);
      assign wr_hit        = write_strobe_i && last_valid && (last_mod == MOD_SEL_W'(m))
                             && mod_in_row[m];
      assign rd_done[m]    = (cnt == CNT_LAST) && !wr_l;
      assign mod_oreg[m]   = oreg_l;

      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            cnt <= '0;
         end else if (ce_i) begin
            if (start) begin
               cnt <= CYCLE_LOAD;
            end else if (mod_busy[m]) begin
               cnt <= cnt - 6'h01;
            end
         end
      end

      // per module, so a later issue to another module cannot shift the watched index
      a_cycle_len: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i)
            start |=> mod_busy[m] [*8])
         else $error("module cycle ended too early");

      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            row_l  <= '0;
            col_l  <= '0;
            bank_l <= 1'b0;
            oreg_l <= '0;
            wr_l   <= 1'b0;
         end else if (ce_i) begin
            if (start) begin
               row_l  <= iss_row;
               col_l  <= iss_col;
               bank_l <= iss_bank;
               oreg_l <= oreg_ptr;
               wr_l   <= iss_write;
            end else if (wr_hit) begin
               wr_l   <= 1'b1;
            end
         end
      end

      // refresh overrides the row path of every module
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            row_en <= 1'b0;
            col_en <= 1'b0;
            we     <= 1'b0;
            bank_q <= 1'b0;
            addr_q <= '0;
         end else if (ce_i) begin
            row_en <= refreshing || mod_in_row[m];
            col_en <= !refreshing && mod_busy[m] && !mod_in_row[m];
            we     <= !refreshing && mod_busy[m] && !mod_in_row[m] && wr_l;
            bank_q <= bank_l;
            addr_q <= refreshing ? ref_row : (mod_in_row[m] ? row_l : col_l);
         end
      end

      assign module_row_addr_enable_o[m] = row_en;
      assign module_col_addr_enable_o[m] = col_en;
      assign ram_we_o[m]                 = we;
      assign ram_bank_o[m]               = bank_q;
      assign ram_addr_o[m]               = addr_q;
   end

   // read completion: starts are spaced, so at most one module finishes per cycle
   always_comb begin
      done_idx = '0;
      done_any = 1'b0;
      for (int i = 0; i < NUM_MODULES; i++) begin
         if (rd_done[i]) begin
            done_idx = MOD_SEL_W'(i);
            done_any = 1'b1;
         end
      end
   end

   assign oport.wr_en   = done_any && ce_i;
   assign oport.wr_idx  = mod_oreg[done_idx];
   assign oport.wr_data = ram_read_data_i[done_idx];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         oport.rd_en  <= 1'b0;
         oport.rd_idx <= '0;
      end else if (ce_i) begin
         oport.rd_en  <= done_any;
         oport.rd_idx <= mod_oreg[done_idx];
      end
   end
   assign read_data_out_bus_o = oport.rd_data;
   assign read_data_valid_o   = oport.rd_valid;

   // refresh scheduling
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_timer <= REF_LOAD_LARGE;
      end else if (ce_i) begin
         if (ref_timer == '0) begin
            ref_timer <= (board_size_i == SIZE_256K || board_size_i == SIZE_128K)
                         ? REF_LOAD_LARGE : REF_LOAD_SMALL;
         end else begin
            ref_timer <= ref_timer - 12'h001;
         end
      end
   end

   // a refresh waits for idle modules and an idle timing generator
   assign ref_start = ref_due && refresh_en && all_idle && !refreshing
                      && (tg_state == TG_IDLE);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_due <= 1'b0;
      end else if (ce_i) begin
         ref_due <= (ref_due && !ref_start) || (ref_timer == '0);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_cnt    <= '0;
         refreshing <= 1'b0;
         ref_row    <= '0;
      end else if (ce_i) begin
         if (ref_start) begin
            ref_cnt    <= CYCLE_LOAD;
            refreshing <= 1'b1;
         end else if (refreshing) begin
            ref_cnt <= ref_cnt - 6'h01;
            if (ref_cnt == CNT_LAST) begin
               refreshing <= 1'b0;
               ref_row    <= ref_row + 7'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         refresh_active_o <= 1'b0;
      end else if (ce_i) begin
         refresh_active_o <= refreshing;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i || !ce_i);

   a_busy_on_clash: assert property ((tg_state == TG_DECODE) && dec_sel && clash
         && !battery_mode |=> board_busy_response_o && (tg_state == TG_IDLE))
      else $error("busy not raised on a clashing select");
   a_inhibit_blocks: assert property ((tg_state == TG_IDLE) && select_inhibit_i
         |=> tg_state == TG_IDLE)
      else $error("start taken while select inhibit high");
   a_battery_no_ops: assert property (battery_mode && $past(battery_mode, 2)
         |-> !issue)
      else $error("operation issued on battery power");
   a_refresh_idle: assert property ($rose(refreshing) |-> $past(all_idle))
      else $error("refresh started with a module busy");
   a_rotate_reg: assert property (issue |=> oreg_ptr == $past(oreg_ptr) + 2'h1)
      else $error("output register not rotated");
   a_row_first: assert property ($rose(module_col_addr_enable_o[0]) && !refresh_active_o
         |-> $past(module_row_addr_enable_o[0]))
      else $error("column phase without preceding row phase");
   a_we_in_col: assert property (ram_we_o[1] |-> module_col_addr_enable_o[1]
         && !module_row_addr_enable_o[1])
      else $error("write enable outside column phase");
   a_read_output: assert property (done_any |-> ##2 read_data_valid_o)
      else $error("read data not delivered two cycles after completion");
   a_refresh_rows: assert property (refreshing |=> module_row_addr_enable_o == 4'hF
         && module_col_addr_enable_o == 4'h0)
      else $error("refresh did not force row enables");
endmodule : dram_board_ctl

/* File: hw/outreg_bank.sv */
// four output registers with a registered read port
`timescale 1ns/10ps
module outreg_bank
   import dram_board_pkg::*;
(
   input  wire logic clk_i,      // board clock
   input  wire logic resetn_i,   // async reset, active low
   input  wire logic ce_i,       // clock enable
   outreg_if.bank    port        // write and read requests
);
   logic [DATA_W-1:0] words [NUM_MODULES];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NUM_MODULES; i++) begin
            words[i] <= '0;
         end
      end else if (ce_i && port.wr_en) begin
         words[port.wr_idx] <= port.wr_data;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         port.rd_data  <= '0;
         port.rd_valid <= 1'b0;
      end else if (ce_i) begin
         port.rd_valid <= port.rd_en;
         if (port.rd_en) begin
            port.rd_data <= words[port.rd_idx];
         end
      end
   end
endmodule : outreg_bank

/* File: include/dram_board_pkg.sv */
// constants, field positions and types shared by the memory board control logic
package dram_board_pkg;
   localparam int CLK_PERIOD_NS    = 8;
   localparam int NUM_MODULES      = 4;
   localparam int ADDR_W           = 17;
   localparam int DATA_W           = 16;
   localparam int MOD_SEL_W        = 2;
   localparam int RAM_ADDR_W       = 7;
   localparam int SMALL_RC_W       = 6;
   localparam int OREG_IDX_W       = 2;
   localparam int CNT_W            = 6;
   localparam int REF_CNT_W        = 12;
   localparam int BOARD_RANGE_W    = 3;

   // address field positions (bit 16 is the high-order physical address bit)
   localparam int MOD_LSB          = 0;
   localparam int BOARD_MSB        = 16;
   localparam int LARGE_BANK_BIT   = 16;
   localparam int LARGE_ROW_LSB    = 9;
   localparam int LARGE_COL_LSB    = 2;
   localparam int SMALL_BANK_BIT   = 14;
   localparam int SMALL_ROW_LSB    = 8;
   localparam int SMALL_COL_LSB    = 2;

   // module cycle timing
   localparam int MOD_CYCLE_NS     = 400;
   localparam int MOD_CYCLE_CYC    = (MOD_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROW_PHASE_NS     = 100;
   localparam int ROW_PHASE_CYC    = (ROW_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] CYCLE_LOAD = CNT_W'(MOD_CYCLE_CYC);
   localparam logic [CNT_W-1:0] COL_START  = CNT_W'(MOD_CYCLE_CYC - ROW_PHASE_CYC);
   localparam logic [CNT_W-1:0] CNT_LAST   = 6'h01;

   // refresh intervals, rounded down to whole cycles
   localparam int REFRESH_SMALL_NS = 25000;
   localparam int REFRESH_LARGE_NS = 13000;
   localparam int REFRESH_SMALL_CYC = REFRESH_SMALL_NS / CLK_PERIOD_NS;
   localparam int REFRESH_LARGE_CYC = REFRESH_LARGE_NS / CLK_PERIOD_NS;
   localparam logic [REF_CNT_W-1:0] REF_LOAD_SMALL = REF_CNT_W'(REFRESH_SMALL_CYC - 1);
   localparam logic [REF_CNT_W-1:0] REF_LOAD_LARGE = REF_CNT_W'(REFRESH_LARGE_CYC - 1);

   typedef enum logic [1:0] {
      SIZE_256K = 2'h0,
      SIZE_128K = 2'h1,
      SIZE_64K  = 2'h2,
      SIZE_32K  = 2'h3
   } board_size_t;

   typedef enum logic [2:0] {
      TG_IDLE   = 3'h1,
      TG_DECODE = 3'h2,
      TG_ISSUE  = 3'h4
   } tg_state_t;
endpackage : dram_board_pkg

/* File: include/outreg_if.sv */
// carrier between the board control and its rotating output register file
`timescale 1ns/10ps
interface outreg_if;
   import dram_board_pkg::*;
   logic                  wr_en;
   logic [OREG_IDX_W-1:0] wr_idx;
   logic [DATA_W-1:0]     wr_data;
   logic                  rd_en;
   logic [OREG_IDX_W-1:0] rd_idx;
   logic [DATA_W-1:0]     rd_data;
   logic                  rd_valid;

   modport ctl  (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, rd_valid);
   modport bank (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, rd_valid);
endinterface : outreg_if

/* File: tb/interleaved_dram_board_control_tb.sv */
// self-checking bench for the interleaved memory board control
`timescale 1ns/10ps
module interleaved_dram_board_control_tb;
   import dram_board_pkg::*;
   logic clk_i, resetn_i, ce_i, op_start_strobe_i, write_strobe_i, select_inhibit_i;
   logic power_good_i, battery_option_i, read_data_valid_o, board_busy_response_o;
   logic refresh_active_o;
   board_size_t board_size_i;
   logic [BOARD_RANGE_W-1:0] board_range_i;
   logic [ADDR_W-1:0] addr_data_in_bus_i;
   logic [NUM_MODULES-1:0][DATA_W-1:0] ram_read_data_i;
   logic [NUM_MODULES-1:0] module_row_addr_enable_o, module_col_addr_enable_o;
   logic [NUM_MODULES-1:0] ram_bank_o, ram_we_o;
   logic [NUM_MODULES-1:0][RAM_ADDR_W-1:0] ram_addr_o;
   logic [DATA_W-1:0] latched_write_data_o, read_data_out_bus_o;
   int error_cnt = 0;
   int total_checks = 0;
   int nb, nv, gap;
   dram_board_ctl dut (.*);
   ram_model ram (.clk_i(clk_i), .row_i(module_row_addr_enable_o),
      .col_i(module_col_addr_enable_o), .we_i(ram_we_o), .bank_i(ram_bank_o),
      .addr_i(ram_addr_o),
      .wdata_i(latched_write_data_o), .rdata_o(ram_read_data_i));
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   // starts every 4 cycles; the word after each address is its write data
   task automatic burst(input logic [ADDR_W-1:0] a0, input int step, input int n, input logic wr);
      logic [ADDR_W-1:0] a;
      nb = 0;
      nv = 0;
      for (int i = 0; i < 90; i++) begin
         a = a0 + ADDR_W'(i / 4 * step);
         op_start_strobe_i = i < 4 * n && i % 4 == 0;
         write_strobe_i = wr && i < 4 * n && i % 4 < 2;
         addr_data_in_bus_i = (i % 4 == 0) ? a : 17'h0C000 + a;
         if (board_busy_response_o === 1'b1) nb++;
         if (read_data_valid_o === 1'b1) begin
            cmp(read_data_out_bus_o, DATA_W'(17'h0C000 + a0 + ADDR_W'(nv * step)));
            nv++;
         end
         tick(1);
      end
   endtask : burst
   // a busy answer means not taken, so the same access is sent again
   task automatic op(input logic [ADDR_W-1:0] a, input logic wr);
      for (int r = 0; r < 3; r++) begin
         burst(a, 0, 1, wr);
         if (nb == 0) break;
      end
   endtask : op
   task automatic wait_refresh(output int g);
      int seen;
      seen = 0;
      g = 0;
      for (int i = 0; i < 3300 && g == 0; i++) begin
         if (refresh_active_o === 1'b1) seen = 1;
         else if (seen == 1) g = i;
         tick(1);
      end
   endtask : wait_refresh
   task automatic t_fill_large;
      for (int a = 0; a < 4; a++) op(ADDR_W'(a), 1'b1);
      op(17'h1C003, 1'b1);
      burst(17'h1C003, 0, 1, 1'b0);
      cmp(16'(nv), 16'h1);
   endtask : t_fill_large
   task automatic t_refresh_large;
      wait_refresh(gap);
      wait_refresh(gap);
      cmp(16'(gap > 1580 && gap < 1700), 16'h1);
   endtask : t_refresh_large
   task automatic t_interleave;
      burst(17'h0, 1, 4, 1'b0);
      cmp(16'(nv * 16 + nb), 16'h40);
   endtask : t_interleave
   task automatic t_busy;
      burst(17'h1, 4, 2, 1'b0);
      cmp(16'(nv * 16 + nb), 16'h11);
   endtask : t_busy
   task automatic t_inhibit;
      select_inhibit_i = 1;
      burst(17'h2, 0, 1, 1'b0);
      cmp(16'(nv + nb), 16'h0);
      select_inhibit_i = 0;
   endtask : t_inhibit
   task automatic t_battery;
      {battery_option_i, power_good_i} = 2'h2;
      burst(17'h2, 0, 1, 1'b0);
      cmp(16'(nv + nb), 16'h0);
      wait_refresh(gap);
      cmp(16'(gap > 0), 16'h1);
      {battery_option_i, power_good_i} = 2'h1;
   endtask : t_battery
   task automatic t_small;
      board_size_i = SIZE_32K;
      wait_refresh(gap);
      wait_refresh(gap);
      cmp(16'(gap > 3080 && gap < 3200), 16'h1);
      op(17'h14002, 1'b1);
      burst(17'h14002, 0, 1, 1'b0);
      cmp(16'(nv), 16'h1);
      burst(17'h2, 0, 1, 1'b0);
      cmp(16'(nv + nb), 16'h0);
   endtask : t_small
   // same module, row and column, opposite banks: each must read back its own word
   task automatic t_bank;
      board_size_i = SIZE_64K;
      op(17'h10001, 1'b1);
      op(17'h14001, 1'b1);
      burst(17'h10001, 0, 1, 1'b0);
      cmp(16'(nv), 16'h1);
      burst(17'h14001, 0, 1, 1'b0);
      cmp(16'(nv), 16'h1);
   endtask : t_bank
   initial begin
      clk_i = 0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      #240000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      {resetn_i, op_start_strobe_i, write_strobe_i, select_inhibit_i, battery_option_i} = '0;
      {ce_i, power_good_i} = 2'h3;
      board_size_i = SIZE_256K;
      board_range_i = 3'h5;
      addr_data_in_bus_i = '0;
      tick(16);
      resetn_i = 1;
      tick(1);
      t_fill_large();
      t_refresh_large();
      t_interleave();
      t_busy();
      t_inhibit();
      t_battery();
      t_small();
      t_bank();
      wrap_up();
   end
endmodule : interleaved_dram_board_control_tb

/* File: tb/ram_model.sv */
// behavioural ram array behind the four module strobes
`timescale 1ns/10ps
module ram_model
   import dram_board_pkg::*;
(
   input  wire logic clk_i, // board clock
   input  wire logic [NUM_MODULES-1:0] row_i, // row phase
   input  wire logic [NUM_MODULES-1:0] col_i, // col phase
   input  wire logic [NUM_MODULES-1:0] we_i, // write enable
   input  wire logic [NUM_MODULES-1:0] bank_i, // bank select
   input  wire logic [NUM_MODULES-1:0][RAM_ADDR_W-1:0] addr_i, // ram address
   input  wire logic [DATA_W-1:0] wdata_i, // write data
   output logic [NUM_MODULES-1:0][DATA_W-1:0] rdata_o // read data
);
   logic [DATA_W-1:0] mem [int];
   logic [NUM_MODULES-1:0][RAM_ADDR_W-1:0] row;
   int key;
   initial rdata_o = '0;
   always @(posedge clk_i) begin
      for (int m = 0; m < NUM_MODULES; m++) begin
         // bank is part of the key, so a lost bank select overwrites the other bank
         key = bank_i[m] * 65536 + m * 16384 + row[m] * 128 + addr_i[m];
         if (row_i[m] && !col_i[m]) row[m] <= addr_i[m];
         if (we_i[m] && col_i[m]) mem[key] = wdata_i;
         // toggles outside the column phase so stale words never pass
         rdata_o[m] <= (col_i[m] && mem.exists(key)) ? mem[key] : ~rdata_o[m];
      end
   end
endmodule : ram_model
